// >>> ispm_ctrl.sv
// Idle and sleep power mode controller with CPU ready delay
//
// Contract
// - Idle sleep gates CPU, keeps peripheral source
// - Idle keeps watchdog RC and secondary running
// - Idle exits only by irq, watchdog, reset
// - Wake holds CPU for ready delay
// - Idle wake resumes matching run source
// - Wake leaves idle bit and select alone
// - Watchdog in idle/sleep wakes to selected
// - Primary idle keeps primary clock and flag
// - Primary idle wake runs CPU on primary
// - Secondary idle drops primary, sets secondary flag
// - Secondary idle wake runs on secondary
// - Secondary idle ignored when oscillator disabled
// - Peripheral clocks wait for secondary start
// - Internal idle drops primary and its flag
// - Internal idle wake runs on internal RC
// - Enabled interrupt flag starts exit
// - Global enable chooses vector branch
// - Execution resumes first cycle after delay
// - Watchdog timeout while running resets
// - Sleep, clear, clock loss clear watchdog
// - Reset exit runs from internal RC
// - Select decode 11 int, 01 sec, 10 pri
// - Neither flag set means internal active
// - Sleep stops clocks, clears status flags
`timescale 1ns/10ps
module ispm_ctrl #(
  parameter int CSD_CNT = ispm_pkg::CSD_CYCLES
) (
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic [ispm_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [ispm_pkg::DATA_W-1:0] WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [ispm_pkg::DATA_W-1:0] RDATA,
  input  wire logic                        SLEEP_INSTR,
  input  wire logic                        WDT_CLEAR_INSTR,
  input  wire logic                        IRQ_FLAG,
  input  wire logic                        WDT_TIMEOUT,
  input  wire logic                        WAKE_RESET,
  input  wire logic                        SEC_OSC_READY,
  input  wire logic                        CLK_FAIL,
  output ispm_pkg::ispm_osc_t              OSC_EN,
  output ispm_pkg::ispm_clk_t              CLK_CTRL,
  output logic                             PRI_ACTIVE,
  output logic                             SEC_ACTIVE,
  output logic                             WDT_CLR,
  output logic                             WDT_RESET,
  output logic                             CPU_RESUME,
  output logic                             BRANCH_VECTOR
);
  import ispm_pkg::*;

  localparam int CNT_W = $clog2(CSD_CNT + 1);

  // Elaboration check: the ready-delay check needs two cycles at least
  if (CSD_CNT < 2) begin : g_bad_csd
    $error("CSD_CNT must be at least two");
  end

  ispm_state_t      state_reg, state_next;
  logic [7:0]       ctrl_reg;
  logic [1:0]       src_reg, src_next;
  logic [1:0]       pend_reg, pend_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             from_sleep_reg, from_sleep_next;
  logic             irq_wake_reg, irq_wake_next;
  logic [1:0]       sync1_reg, sync2_reg;
  logic             fail_prev_reg;
  logic             sleeping, wake, fail_edge, accept_sleep;
  logic [1:0]       css_src;

  wire idle_sel = ctrl_reg[CTRL_IDLE];
  wire [1:0] css = ctrl_reg[CTRL_CSS_LO +: 2];
  wire sec_en = ctrl_reg[CTRL_SECEN];
  wire gie = ctrl_reg[CTRL_GIE];
  wire wdt_en = ctrl_reg[CTRL_WDTEN];
  wire fscm_en = ctrl_reg[CTRL_FSCMEN];
  wire sec_ready = sync2_reg[0];
  wire clk_fail = sync2_reg[1];

  // Two-flop synchronisers for the pin-level oscillator inputs
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_sync
    always_ff @(posedge CLK) begin
      if (RST) begin
        sync1_reg[gi] <= 1'b0;
        sync2_reg[gi] <= 1'b0;
      end else begin
        sync1_reg[gi] <= (gi == 0) ? SEC_OSC_READY : CLK_FAIL;
        sync2_reg[gi] <= sync1_reg[gi];
      end
    end
  end

  // Select decode; both 00 and 11 mean the internal RC
  always_comb begin
    case (css)
      SRC_PRI: css_src = SRC_PRI;
      SRC_SEC: css_src = SRC_SEC;
      default: css_src = SRC_INT;
    endcase
  end

  // Low-power states where no code runs
  assign sleeping = (state_reg == ST_IDLE) || (state_reg == ST_SLEEP) ||
                    (state_reg == ST_SEC_WAIT);
  // Only these three events may end a low-power state
  assign wake = sleeping &&
                (IRQ_FLAG || WDT_TIMEOUT || WAKE_RESET);
  // A sleep request for secondary idle is void without its enable
  assign accept_sleep = SLEEP_INSTR && (state_reg == ST_RUN) &&
                        !(idle_sel && css_src == SRC_SEC &&
                          !sec_en);
  assign fail_edge = clk_fail && !fail_prev_reg;

  // Mode sequencing
  always_comb begin
    state_next      = state_reg;
    src_next        = src_reg;
    pend_next       = pend_reg;
    cnt_next        = cnt_reg;
    from_sleep_next = from_sleep_reg;
    irq_wake_next   = irq_wake_reg;
    case (state_reg)
      ST_RUN: begin
        if (accept_sleep) begin
          pend_next = css_src;
          if (!idle_sel) begin
            state_next = ST_SLEEP;
          end else if (css_src == SRC_SEC && !sec_ready) begin
            state_next = ST_SEC_WAIT;
          end else begin
            state_next = ST_IDLE;
            src_next   = css_src;
          end
        end
      end
      ST_SEC_WAIT: begin
        // Secondary takes over only once it oscillates
        if (sec_ready) begin
          state_next = ST_IDLE;
          src_next   = SRC_SEC;
        end
      end
      ST_READY: begin
        if (cnt_reg == '0) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: ;
    endcase
    if (wake) begin
      state_next      = ST_READY;
      cnt_next        = CNT_W'(CSD_CNT - 1);
      from_sleep_next = (state_reg == ST_SLEEP);
      irq_wake_next   = IRQ_FLAG && !WAKE_RESET;
      if (WAKE_RESET) begin
        src_next = SRC_INT;
      end else if (state_reg == ST_SLEEP) begin
        src_next = css_src;
      end else if (state_reg == ST_SEC_WAIT) begin
        src_next = SRC_SEC;
      end else begin
        src_next = src_reg;
      end
    end
  end

  // State registers; after reset the core runs from the internal RC
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg      <= ST_RUN;
      src_reg        <= SRC_INT;
      pend_reg       <= SRC_INT;
      cnt_reg        <= '0;
      from_sleep_reg <= 1'b0;
      irq_wake_reg   <= 1'b0;
      fail_prev_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      src_reg        <= src_next;
      pend_reg       <= pend_next;
      cnt_reg        <= cnt_next;
      from_sleep_reg <= from_sleep_next;
      irq_wake_reg   <= irq_wake_next;
      fail_prev_reg  <= clk_fail;
    end
  end

  // Control register: only software writes it, wake never touches it
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
    end else if (WR && ADDR == CTRL_OFS) begin
      ctrl_reg <= WDATA & CTRL_WMASK;
    end
  end

  // Read port; data valid the cycle after the strobe, else zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD && ADDR == CTRL_OFS) begin
      RDATA <= ctrl_reg;
    end else if (RD && ADDR == STAT_OFS) begin
      RDATA <= {3'h0, CLK_CTRL.periph_en, CLK_CTRL.cpu_en,
                !PRI_ACTIVE && !SEC_ACTIVE,
                SEC_ACTIVE, PRI_ACTIVE};
    end else begin
      RDATA <= '0;
    end
  end

  // Clock routing outputs, registered from the next state so the CPU
  // gate enable changes only at edges; the latch-based gate cell that
  // consumes it then switches the CPU clock in its low phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      CLK_CTRL <= '{src: SRC_INT, cpu_en: 1'b1, periph_en: 1'b1};
    end else begin
      CLK_CTRL.src       <= src_next;
      CLK_CTRL.cpu_en    <= (state_next == ST_RUN);
      CLK_CTRL.periph_en <= (state_next == ST_RUN) ||
                            (state_next == ST_IDLE) ||
                            (state_next == ST_READY);
    end
  end

  // Status flags: in sleep both clear, otherwise they follow the source
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRI_ACTIVE <= 1'b0;
      SEC_ACTIVE <= 1'b0;
    end else begin
      PRI_ACTIVE <= (state_next != ST_SLEEP) &&
                    (src_next == SRC_PRI);
      SEC_ACTIVE <= (state_next != ST_SLEEP) &&
                    (src_next == SRC_SEC);
    end
  end

  // Oscillator run requests
  always_ff @(posedge CLK) begin
    if (RST) begin
      OSC_EN <= '{pri: 1'b0, sec: 1'b0, internal_rc_oscillator: 1'b1};
    end else begin
      OSC_EN.pri   <= (state_next != ST_SLEEP) &&
                      (src_next == SRC_PRI);
      OSC_EN.sec   <= ctrl_reg[CTRL_SECEN] ||
                      ((state_next != ST_SLEEP) &&
                       (src_next == SRC_SEC));
      OSC_EN.internal_rc_oscillator <= ctrl_reg[CTRL_WDTEN] || ctrl_reg[CTRL_FSCMEN] ||
                      ((state_next != ST_SLEEP) &&
                       (src_next == SRC_INT));
    end
  end

  // Watchdog side effects and resume pulses
  always_ff @(posedge CLK) begin
    if (RST) begin
      WDT_CLR       <= 1'b0;
      WDT_RESET     <= 1'b0;
      CPU_RESUME    <= 1'b0;
      BRANCH_VECTOR <= 1'b0;
    end else begin
      WDT_CLR       <= (SLEEP_INSTR && state_reg == ST_RUN) ||
                       WDT_CLEAR_INSTR ||
                       (fscm_en && fail_edge);
      WDT_RESET     <= WDT_TIMEOUT && (state_reg == ST_RUN);
      CPU_RESUME    <= (state_reg == ST_READY) && (cnt_reg == '0);
      BRANCH_VECTOR <= (state_reg == ST_READY) && (cnt_reg == '0) &&
                       irq_wake_reg && gie;
    end
  end

  // Lint sink; from_sleep_reg, pend_reg and wdt_en feed no logic
  wire unused_ok = from_sleep_reg ^ wdt_en ^ sec_en ^ (|pend_reg);

  // Checks on the mode sequencing
  cpu_gate_idle_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == ST_IDLE) |-> !CLK_CTRL.cpu_en && CLK_CTRL.periph_en)
    else $error("CPU clock running in idle");

  ready_delay_a: assert property (@(posedge CLK) disable iff (RST)
    $rose(state_reg == ST_READY) |->
      (state_reg == ST_READY && !CLK_CTRL.cpu_en)[*2])
    else $error("CPU ready delay cut short");

  idle_exit_cause_a: assert property (@(posedge CLK) disable iff (RST)
    (sleeping && !IRQ_FLAG && !WDT_TIMEOUT && !WAKE_RESET) |=>
      (state_reg != ST_READY) && (state_reg != ST_RUN))
    else $error("Idle left without a wake event");

  ctrl_stable_a: assert property (@(posedge CLK) disable iff (RST)
    (wake && !WR) |=> $stable(ctrl_reg))
    else $error("Wake altered the control bits");

  resume_src_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == ST_IDLE && wake && !WAKE_RESET) |=>
      (CLK_CTRL.src == $past(src_reg)))
    else $error("Idle wake changed the clock source");

  reset_wake_a: assert property (@(posedge CLK) disable iff (RST)
    (wake && WAKE_RESET) |=> (CLK_CTRL.src == SRC_INT))
    else $error("Reset wake not on internal RC");

  sec_ignore_a: assert property (@(posedge CLK) disable iff (RST)
    (SLEEP_INSTR && state_reg == ST_RUN && idle_sel &&
     css_src == SRC_SEC && !sec_en) |=> (state_reg == ST_RUN))
    else $error("Secondary idle entered while disabled");

  sec_wait_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == ST_SEC_WAIT) |-> !CLK_CTRL.periph_en)
    else $error("Peripherals clocked before secondary start");

  wdt_reset_a: assert property (@(posedge CLK) disable iff (RST)
    (WDT_TIMEOUT && state_reg == ST_RUN) |=> WDT_RESET && !CPU_RESUME)
    else $error("Run-mode timeout without reset");

  sleep_flags_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == ST_SLEEP) |-> !PRI_ACTIVE && !SEC_ACTIVE)
    else $error("Status flags set in sleep");

  resume_first_a: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == ST_READY && cnt_reg == '0) |=>
      CLK_CTRL.cpu_en && CPU_RESUME)
    else $error("Execution not resumed after delay");

  branch_gie_a: assert property (@(posedge CLK) disable iff (RST)
    BRANCH_VECTOR |-> CPU_RESUME && gie && $past(irq_wake_reg))
    else $error("Vector branch without enable");

  wdt_clear_a: assert property (@(posedge CLK) disable iff (RST)
    WDT_CLEAR_INSTR |=> WDT_CLR)
    else $error("Watchdog not cleared");

endmodule

// >>> ispm_pkg.sv
// Shared constants and types for the idle and sleep power mode controller
package ispm_pkg;

  // Register port geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STAT_OFS    = 8'h04;

  // Control register field positions
  localparam int          CTRL_CSS_LO = 0;
  localparam int          CTRL_SECEN  = 2;
  localparam int          CTRL_GIE    = 3;
  localparam int          CTRL_WDTEN  = 4;
  localparam int          CTRL_FSCMEN = 5;
  localparam int          CTRL_IDLE   = 7;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  CTRL_WMASK  = 8'hbf;

  // Status register field positions
  localparam int          STAT_PRI    = 0;
  localparam int          STAT_SEC    = 1;
  localparam int          STAT_INT    = 2;
  localparam int          STAT_CPU    = 3;
  localparam int          STAT_PERI   = 4;

  // Clock source select codes
  localparam logic [1:0]  SRC_NONE    = 2'h0;
  localparam logic [1:0]  SRC_SEC     = 2'h1;
  localparam logic [1:0]  SRC_PRI     = 2'h2;
  localparam logic [1:0]  SRC_INT     = 2'h3;

  // CPU ready delay, time and derived cycle count (rounded up)
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          CSD_TIME_NS   = 200;
  localparam int          CSD_CYCLES    =
    (CSD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_RUN, ST_IDLE, ST_SLEEP, ST_SEC_WAIT, ST_READY
  } ispm_state_t;

  // Oscillator run requests
  typedef struct packed {
    logic pri;
    logic sec;
    logic internal_rc_oscillator;
  } ispm_osc_t;

  // Clock routing: source, CPU gate enable, peripheral gate enable
  typedef struct packed {
    logic [1:0] src;
    logic       cpu_en;
    logic       periph_en;
  } ispm_clk_t;

endpackage

// >>> ispm_osc_model.sv
// Secondary oscillator model with a slow start-up
`timescale 1ns/10ps
module ispm_osc_model #(
  parameter int START = 8
) (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire ispm_pkg::ispm_osc_t OSC_EN,
  output logic                     SEC_OSC_READY
);
  import ispm_pkg::*;

  int cnt;

  // Late start exercises the peripheral hold-off; stopping drops at once
  always_ff @(posedge CLK) begin
    if (RST || !OSC_EN.sec) begin
      cnt <= 0;
      SEC_OSC_READY <= 1'b0;
    end else if (cnt < START) begin
      cnt <= cnt + 1;
    end else begin
      SEC_OSC_READY <= 1'b1;
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the idle and sleep power mode controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("BAD %s exp %h got %h", nm, exp, got); \
  end \
end
module testbench;
  import ispm_pkg::*;

  localparam int CSD = 3;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic       slp = 1'b0;
  logic       wclr = 1'b0;
  logic       irq = 1'b0;
  logic       wdt_to = 1'b0;
  logic       wrst = 1'b0;
  logic       clk_fail = 1'b0;
  logic       sec_rdy;
  ispm_osc_t  osc_en;
  ispm_clk_t  cc;
  logic       pri_act;
  logic       sec_act;
  logic       wdt_clr;
  logic       wdt_reset;
  logic       resume;
  logic       branch;
  int         fail_count = 0;
  int         checks_done = 0;
  int         i;

  always #5 clk = ~clk;

  ispm_ctrl #(.CSD_CNT(CSD)) ispm_ctrl_i (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .SLEEP_INSTR(slp),
    .WDT_CLEAR_INSTR(wclr), .IRQ_FLAG(irq), .WDT_TIMEOUT(wdt_to),
    .WAKE_RESET(wrst), .SEC_OSC_READY(sec_rdy), .CLK_FAIL(clk_fail),
    .OSC_EN(osc_en), .CLK_CTRL(cc), .PRI_ACTIVE(pri_act),
    .SEC_ACTIVE(sec_act), .WDT_CLR(wdt_clr), .WDT_RESET(wdt_reset),
    .CPU_RESUME(resume), .BRANCH_VECTOR(branch)
  );

  ispm_osc_model ispm_osc_model_i (
    .CLK(clk), .RST(rst), .OSC_EN(osc_en), .SEC_OSC_READY(sec_rdy)
  );

  task results;
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask

  task sleep_go;
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(negedge clk);
  endtask

  // Kind 0 interrupt, 1 watchdog, 2 reset; resume lands CSD+1 edges later
  task wake(input int k, input logic br);
    @(posedge clk);
    irq <= (k == 0);
    wdt_to <= (k == 1);
    wrst <= (k == 2);
    @(posedge clk);
    irq <= 1'b0;
    wdt_to <= 1'b0;
    wrst <= 1'b0;
    @(negedge clk);
    `CHK("wdt_reset", 1'b0, wdt_reset)
    repeat (CSD - 1) @(posedge clk);
    @(negedge clk);
    `CHK("early", 1'b0, resume)
    @(posedge clk);
    @(negedge clk);
    `CHK("resume", 1'b1, resume)
    `CHK("cpu_en", 1'b1, cc.cpu_en)
    `CHK("branch", br, branch)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_OFS, CTRL_RST);
    rd(STAT_OFS, 8'h1c);
    rd(8'h08, 8'h00);
    wr(CTRL_OFS, 8'hff);
    rd(CTRL_OFS, 8'hbf);
    // Internal idle, no early exit, interrupt wake into the vector
    wr(CTRL_OFS, 8'h98);
    sleep_go;
    `CHK("cpu_en", 1'b0, cc.cpu_en)
    `CHK("periph", 1'b1, cc.periph_en)
    `CHK("slp_clr", 1'b1, wdt_clr)
    `CHK("pri_osc", 1'b0, osc_en.pri)
    `CHK("internal_rc_oscillator", 1'b1, osc_en.internal_rc_oscillator)
    wr(CTRL_OFS, 8'h98);
    @(posedge clk);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    @(negedge clk);
    `CHK("clr_instr", 1'b1, wdt_clr)
    `CHK("still_idle", 1'b0, cc.cpu_en)
    wake(0, 1'b1);
    `CHK("src", SRC_INT, cc.src)
    rd(CTRL_OFS, 8'h98);
    // Primary idle, watchdog wake
    wr(CTRL_OFS, 8'h82);
    sleep_go;
    `CHK("src", SRC_PRI, cc.src)
    `CHK("pri_osc", 1'b1, osc_en.pri)
    `CHK("pri_act", 1'b1, pri_act)
    wake(1, 1'b0);
    `CHK("src", SRC_PRI, cc.src)
    `CHK("pri_act", 1'b1, pri_act)
    // Secondary idle with the oscillator disabled is ignored
    wr(CTRL_OFS, 8'h81);
    sleep_go;
    `CHK("cpu_en", 1'b1, cc.cpu_en)
    // Secondary idle entered before the oscillator runs
    wr(CTRL_OFS, 8'h85);
    sleep_go;
    `CHK("periph", 1'b0, cc.periph_en)
    for (i = 0; i < 40 && sec_act !== 1'b1; i++) @(negedge clk);
    `CHK("sec_act", 1'b1, sec_act)
    `CHK("pri_act", 1'b0, pri_act)
    `CHK("src", SRC_SEC, cc.src)
    `CHK("periph", 1'b1, cc.periph_en)
    wake(0, 1'b0);
    `CHK("src", SRC_SEC, cc.src)
    `CHK("sec_osc", 1'b1, osc_en.sec)
    sleep_go;
    wake(2, 1'b0);
    `CHK("src", SRC_INT, cc.src)
    // Sleep with the watchdog on, watchdog wake to the selected source
    wr(CTRL_OFS, 8'h1a);
    sleep_go;
    `CHK("periph", 1'b0, cc.periph_en)
    rd(STAT_OFS, 8'h04);
    wake(1, 1'b0);
    `CHK("src", SRC_PRI, cc.src)
    // Watchdog time-out while running
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    @(negedge clk);
    `CHK("wdt_reset", 1'b1, wdt_reset)
    `CHK("resume", 1'b0, resume)
    // Clock loss with the monitor enabled clears the watchdog
    wr(CTRL_OFS, 8'h20);
    @(posedge clk);
    clk_fail <= 1'b1;
    for (i = 0; i < 8 && wdt_clr !== 1'b1; i++) @(negedge clk);
    `CHK("loss_clr", 1'b1, wdt_clr)
    results;
  end

  // Hang guard well beyond the hundred or so cycles of the sequence
  initial begin
    #20000;
    fail_count++;
    results;
  end
endmodule
